// ===== core/cbeq_pkg.sv
// Purpose: Constants for the cache and bus event qualifier
// Assumes: 50 MHz core clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit words
//
// What this block does
// - Code 4b/01 counts all-level prefetch misses
// - Count at execution, speculative included
// - Code 4b/02 counts second-level prefetch misses
// - Code 4c/00 counts loads hitting pending prefetch
// - Code 4e/10 counts first-level prefetch requests
// - Rejected and resubmitted requests each count
// - Code 60 adds pending full-line reads
// - Read pending from issue to last chunk
// - Only cacheable data-miss or prefetcher reads
// - Exclude ownership reads, fetches, other traffic
// - Code 61 counts own bus-not-ready assertions
// - Assert not-ready near transaction capacity
// - Each not-ready assertion spans two cycles
// - No new transaction while not-ready asserted
// - Code 62 counts data-valid bus cycles
// - Own-agent mask counts only own data
// - All-agents mask counts any agent data
package cbeq_pkg;
  localparam logic [7:0] EV_PRE_MISS = 8'h4b;
  localparam logic [7:0] EV_LOAD_HIT_PRE = 8'h4c;
  localparam logic [7:0] EV_L1_PF_REQ = 8'h4e;
  localparam logic [7:0] EV_RD_OUTST = 8'h60;
  localparam logic [7:0] EV_HOLD_OFF = 8'h61;
  localparam logic [7:0] EV_DATA_VALID = 8'h62;
  localparam logic [7:0] UM_ALL_LEVEL = 8'h01;
  localparam logic [7:0] UM_SECOND_LEVEL = 8'h02;
  localparam logic [7:0] UM_NONE = 8'h00;
  localparam logic [7:0] UM_L1_PF_REQ = 8'h10;
  localparam logic [7:0] UM_THIS_AGENT = 8'h40;
  localparam logic [7:0] UM_ALL_AGENTS = 8'hc0;
  localparam int AGENT_BIT = 6;
  localparam logic [7:0] ADDR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_THRESH = 8'h0c;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [3:0] THRESH_RESET = 4'h6;
  localparam int TXN_MAX = 8;
  localparam int LINE_CHUNKS = 4;
  localparam int HOLD_CYCLES = 2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : cbeq_pkg

// ===== core/cbeq_read_slot.sv
// Purpose: Tracks one outstanding full-line bus read
// Assumes: Issue and chunk strobes are one-cycle pulses on clk
// Notes: Pending from issue cycle until last chunk arrives
`timescale 1ns/100ps
module cbeq_read_slot (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input wire logic chunk,
  output logic pending
);
  logic pendingR;
  logic [1:0] chunkCntR;
  wire lastChunk = pendingR && chunk && (chunkCntR == 2'(cbeq_pkg::LINE_CHUNKS - 1));

  // Pending is seen combinationally in the issue cycle itself
  assign pending = pendingR || issue;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pendingR <= 1'b0;
      chunkCntR <= 2'h0;
    end else if (issue) begin
      pendingR <= 1'b1;
      chunkCntR <= 2'h0;
    end else if (lastChunk) begin
      pendingR <= 1'b0;
      chunkCntR <= 2'h0;
    end else if (pendingR && chunk) begin
      chunkCntR <= chunkCntR + 2'h1;
    end
  end
endmodule : cbeq_read_slot

// ===== core/cbeq_qualifier.sv
// Purpose: Decodes event code and mask into per-cycle increments
// Assumes: Core events are one-cycle pulses on clk; bus pins pass a 3-flop filter
// Notes: Registers: select, accumulated count, status, hold-off threshold
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module cbeq_qualifier (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic allLevelPfMiss,
  input wire logic secondLevelPfMiss,
  input wire logic loadHitPendingPf,
  input wire logic firstLevelPfReq,
  input wire logic [2:0] rdIssueSlot,
  input wire logic rdIssue,
  input wire logic rdIssueQualified,
  input wire logic [2:0] rdChunkSlot,
  input wire logic rdChunk,
  input wire logic [3:0] txnCount,
  input wire logic dataValidPin,
  input wire logic ownDataDrive,
  output logic busNotReadyOut,
  output logic busNotReadyOe,
  output logic [3:0] incCount
);
  // Bus-side pin filter: three flops, change accepted when last two agree
  logic [2:0] dvSyncR;
  logic dataValidR;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dvSyncR <= 3'h0;
      dataValidR <= 1'b0;
    end else begin
      dvSyncR <= {dvSyncR[1:0], dataValidPin};
      if (dvSyncR[1] == dvSyncR[2]) dataValidR <= dvSyncR[2];
    end
  end

  // Software-visible registers
  logic [31:0] selectR;
  logic [31:0] countR;
  logic [31:0] holdCntR;
  logic [3:0] threshR;
  wire [7:0] evCode = selectR[7:0];
  wire [7:0] uMask = selectR[15:8];

  // Outstanding-read slots, one per allowed bus transaction
  logic [cbeq_pkg::TXN_MAX-1:0] slotPending;
  genvar gi;
  generate
    for (gi = 0; gi < cbeq_pkg::TXN_MAX; gi++) begin : gSlot
      // Only qualified full-line cacheable data reads enter a slot
      wire issueHere = rdIssue && rdIssueQualified && (rdIssueSlot == 3'(gi));
      wire chunkHere = rdChunk && (rdChunkSlot == 3'(gi));
      cbeq_read_slot uSlot (
        .clk(clk),
        .sys_rst(sys_rst),
        .issue(issueHere),
        .chunk(chunkHere),
        .pending(slotPending[gi])
      );
    end
  endgenerate

  // Population count of pending reads
  logic [3:0] pendingCnt;
  always_comb begin
    pendingCnt = 4'h0;
    for (int i = 0; i < cbeq_pkg::TXN_MAX; i++) begin
      pendingCnt = pendingCnt + {3'h0, slotPending[i]};
    end
  end

  // Hold-off generator: asserts for two cycles when near capacity
  typedef enum logic [2:0] {
    HO_IDLE = 3'b001,
    HO_FIRST = 3'b010,
    HO_SECOND = 3'b100
  } cbeq_hold_e;
  cbeq_hold_e holdR;
  cbeq_hold_e holdNxt;
  wire nearFull = (txnCount >= threshR);
  always_comb begin
    unique case (holdR)
      HO_IDLE: holdNxt = nearFull ? HO_FIRST : HO_IDLE;
      HO_FIRST: holdNxt = HO_SECOND;
      HO_SECOND: holdNxt = HO_IDLE;
      default: holdNxt = HO_IDLE;
    endcase
  end
  wire holdStart = (holdR == HO_IDLE) && nearFull;
  // Not-ready level and enable rise and fall together: the wire is driven high while asserted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      holdR <= HO_IDLE;
      busNotReadyOut <= 1'b0;
      busNotReadyOe <= 1'b0;
    end else begin
      holdR <= holdNxt;
      busNotReadyOut <= (holdNxt != HO_IDLE);
      busNotReadyOe <= (holdNxt != HO_IDLE);
    end
  end

  // Event decode; unlisted pairs give zero
  wire selAllLevel = (evCode == cbeq_pkg::EV_PRE_MISS) && (uMask == cbeq_pkg::UM_ALL_LEVEL);
  wire selSecond = (evCode == cbeq_pkg::EV_PRE_MISS) && (uMask == cbeq_pkg::UM_SECOND_LEVEL);
  wire selLoadHit = (evCode == cbeq_pkg::EV_LOAD_HIT_PRE) && (uMask == cbeq_pkg::UM_NONE);
  wire selPfReq = (evCode == cbeq_pkg::EV_L1_PF_REQ) && (uMask == cbeq_pkg::UM_L1_PF_REQ);
  wire selRdOut = (evCode == cbeq_pkg::EV_RD_OUTST);
  wire selHoldOff = (evCode == cbeq_pkg::EV_HOLD_OFF);
  wire selDvOwn = (evCode == cbeq_pkg::EV_DATA_VALID) && (uMask == cbeq_pkg::UM_THIS_AGENT);
  wire selDvAll = (evCode == cbeq_pkg::EV_DATA_VALID) && (uMask == cbeq_pkg::UM_ALL_AGENTS);

  // Increment select; speculative executions are counted since misses arrive at execute
  logic [3:0] incNxt;
  always_comb begin
    incNxt = 4'h0;
    if (selAllLevel) incNxt = {3'h0, allLevelPfMiss};
    if (selSecond) incNxt = {3'h0, secondLevelPfMiss};
    if (selLoadHit) incNxt = {3'h0, loadHitPendingPf};
    if (selPfReq) incNxt = {3'h0, firstLevelPfReq};
    if (selRdOut) incNxt = pendingCnt;
    if (selHoldOff) incNxt = {3'h0, holdStart};
    if (selDvOwn) incNxt = {3'h0, dataValidR && ownDataDrive};
    if (selDvAll) incNxt = {3'h0, dataValidR};
  end

  // AXI4-Lite write path: address and data taken in either order
  logic awHeldR;
  logic wHeldR;
  logic [7:0] awAddrR;
  logic [31:0] wDataR;
  logic [3:0] wStrbR;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire wrGo = awHeldR && wHeldR && !s_axi_bvalid;
  wire wrSel = wrGo && (awAddrR == cbeq_pkg::ADDR_SELECT);
  wire wrCnt = wrGo && (awAddrR == cbeq_pkg::ADDR_COUNT);
  wire wrThr = wrGo && (awAddrR == cbeq_pkg::ADDR_THRESH);
  wire wrKnown = wrSel || wrCnt || wrThr || (awAddrR == cbeq_pkg::ADDR_STATUS);
  logic [31:0] selMerged;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      selMerged[b*8 +: 8] = wStrbR[b] ? wDataR[b*8 +: 8] : selectR[b*8 +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeldR <= 1'b0;
      wHeldR <= 1'b0;
      awAddrR <= 8'h00;
      wDataR <= 32'h0000_0000;
      wStrbR <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cbeq_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !awHeldR && !awTake && !s_axi_bvalid;
      s_axi_wready <= !wHeldR && !wTake && !s_axi_bvalid;
      if (awTake) begin
        awHeldR <= 1'b1;
        awAddrR <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (wTake) begin
        wHeldR <= 1'b1;
        wDataR <= s_axi_wdata;
        wStrbR <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeldR <= 1'b0;
        wHeldR <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the held address decides; the live bus may already carry the next one
        s_axi_bresp <= wrKnown ? cbeq_pkg::AXI_OKAY : cbeq_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register state: select, threshold, accumulated count, hold-off tally
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selectR <= cbeq_pkg::SELECT_RESET;
      threshR <= cbeq_pkg::THRESH_RESET;
      countR <= 32'h0000_0000;
      holdCntR <= 32'h0000_0000;
      incCount <= 4'h0;
    end else begin
      incCount <= incNxt;
      if (wrSel) selectR <= selMerged;
      if (wrThr) threshR <= wDataR[3:0];
      // Hardware increment adds on top of a software write so no event is lost
      if (wrCnt) countR <= wDataR + {28'h0, incNxt};
      else countR <= countR + {28'h0, incNxt};
      if (holdStart) holdCntR <= holdCntR + 32'h1;
    end
  end

  // AXI4-Lite read path
  // Upper address bits are ignored, so the four registers alias across the space
  wire [7:0] rdAddr = {s_axi_araddr[7:2], 2'h0};
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rdSel = (rdAddr == cbeq_pkg::ADDR_SELECT);
  wire rdCnt = (rdAddr == cbeq_pkg::ADDR_COUNT);
  wire rdSta = (rdAddr == cbeq_pkg::ADDR_STATUS);
  wire rdThr = (rdAddr == cbeq_pkg::ADDR_THRESH);
  wire rdHit = rdSel || rdCnt || rdSta || rdThr;
  wire [31:0] statusWord = {holdCntR[15:0], 4'h0, pendingCnt, 5'h0, holdR};
  wire [31:0] rdMux = rdSel ? selectR :
                      rdCnt ? countR :
                      rdSta ? statusWord :
                      rdThr ? {28'h0, threshR} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cbeq_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !arTake;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? cbeq_pkg::AXI_OKAY : cbeq_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  sequence sHoldTwo;
    busNotReadyOut [*2];
  endsequence
  a_hold_two_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busNotReadyOut) |-> sHoldTwo ##1 !busNotReadyOut)
    else $error("Not-ready did not span two cycles");
  a_hold_on_full: assert property (@(posedge clk) disable iff (sys_rst)
    (holdR == HO_IDLE) && nearFull |=> busNotReadyOut)
    else $error("Not-ready missed near capacity");
  a_unlisted_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !(selAllLevel || selSecond || selLoadHit || selPfReq || selRdOut || selHoldOff
      || selDvOwn || selDvAll) |=> incCount == 4'h0)
    else $error("Increment on unlisted pair");
  a_all_level: assert property (@(posedge clk) disable iff (sys_rst)
    selAllLevel && allLevelPfMiss |=> incCount == 4'h1)
    else $error("All-level miss not counted");
  a_second_level: assert property (@(posedge clk) disable iff (sys_rst)
    selSecond && secondLevelPfMiss |=> incCount == 4'h1)
    else $error("Second-level miss not counted");
  a_load_hit: assert property (@(posedge clk) disable iff (sys_rst)
    selLoadHit && loadHitPendingPf |=> incCount == 4'h1)
    else $error("Load hit on prefetch not counted");
  a_pf_request: assert property (@(posedge clk) disable iff (sys_rst)
    selPfReq |=> incCount == {3'h0, $past(firstLevelPfReq)})
    else $error("Prefetch request count wrong");
  a_read_outst: assert property (@(posedge clk) disable iff (sys_rst)
    selRdOut |=> incCount == $past(pendingCnt))
    else $error("Outstanding read sum wrong");
  a_unqual_read: assert property (@(posedge clk) disable iff (sys_rst)
    rdIssue && !rdIssueQualified && slotPending == '0 ##1 !rdIssue |-> slotPending == '0)
    else $error("Unqualified read became pending");
  a_dv_own: assert property (@(posedge clk) disable iff (sys_rst)
    selDvOwn && !ownDataDrive |=> incCount == 4'h0)
    else $error("Foreign data counted as own");
  a_dv_all: assert property (@(posedge clk) disable iff (sys_rst)
    selDvAll && dataValidR |=> incCount == 4'h1)
    else $error("Data cycle not counted");
  a_hold_count: assert property (@(posedge clk) disable iff (sys_rst)
    selHoldOff && holdStart |=> incCount == 4'h1 ##1 busNotReadyOut)
    else $error("Not-ready assertion not counted");

  // A counted hold-off is two high cycles, then at least one low cycle
  sequence sHoldStart;
    (holdR == HO_IDLE) && nearFull;
  endsequence
  sequence sHoldPair;
    busNotReadyOut ##1 busNotReadyOut;
  endsequence
  a_hold_seq: assert property (@(posedge clk) disable iff (sys_rst)
    sHoldStart |=> sHoldPair ##1 !busNotReadyOut)
    else $error("Not-ready sequence broken");
  a_hold_gap: assert property (@(posedge clk) disable iff (sys_rst)
    sHoldPair |=> !busNotReadyOut)
    else $error("Not-ready held past two cycles");
  a_hold_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (holdR == HO_IDLE) && !nearFull |=> !busNotReadyOut)
    else $error("Not-ready raised without load");
  a_oe_level: assert property (@(posedge clk) disable iff (sys_rst)
    busNotReadyOe == busNotReadyOut)
    else $error("Not-ready enable and level differ");
  a_hold_tally: assert property (@(posedge clk) disable iff (sys_rst)
    holdStart |=> holdCntR == $past(holdCntR) + 32'h1)
    else $error("Hold-off tally missed a start");

  // Selected core events give nothing in cycles without a pulse
  a_all_level_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    selAllLevel && !allLevelPfMiss |=> incCount == 4'h0)
    else $error("All-level increment without a miss");
  a_second_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    selSecond && !secondLevelPfMiss |=> incCount == 4'h0)
    else $error("Second-level increment without a miss");
  a_load_hit_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    selLoadHit && !loadHitPendingPf |=> incCount == 4'h0)
    else $error("Load-hit increment without a load");

  // Data-valid cycles after the filter; a disagreeing pair must not move it
  a_dv_own_count: assert property (@(posedge clk) disable iff (sys_rst)
    selDvOwn && dataValidR && ownDataDrive |=> incCount == 4'h1)
    else $error("Own data cycle not counted");
  a_dv_all_idle: assert property (@(posedge clk) disable iff (sys_rst)
    selDvAll && !dataValidR |=> incCount == 4'h0)
    else $error("Idle bus cycle counted");
  a_dv_filter_hold: assert property (@(posedge clk) disable iff (sys_rst)
    dvSyncR[1] != dvSyncR[2] |=> $stable(dataValidR))
    else $error("Filtered data-valid moved on a glitch");

  // A qualified read stays pending after its issue cycle
  a_read_held: assert property (@(posedge clk) disable iff (sys_rst)
    rdIssue && rdIssueQualified ##1 !rdIssue |-> pendingCnt != 4'h0)
    else $error("Issued read not held pending");
  a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
    selRdOut && slotPending == '0 |=> incCount == 4'h0)
    else $error("Outstanding sum without pending reads");
endmodule : cbeq_qualifier

// ===== test/cbeq_bus_agent.sv
// Purpose: Far-side bus agents and memory for the event qualifier
// Assumes: One bench process calls the tasks at a time
// Notes: Slot and qualifier lines carry junk outside their strobes
`timescale 1ns/100ps
module cbeq_bus_agent (
  input wire logic clk,
  input wire logic busNotReadyOut,
  output logic [2:0] rdIssueSlot,
  output logic rdIssue,
  output logic rdIssueQualified,
  output logic [2:0] rdChunkSlot,
  output logic rdChunk,
  output logic [3:0] txnCount,
  output logic dataValidPin
);
  // Quiet bus at time zero
  initial begin
    {rdIssueSlot, rdIssue, rdIssueQualified} = 5'h14;
    {rdChunkSlot, rdChunk, txnCount, dataValidPin} = 9'h140;
  end

  // One line read: issue, a gap, then every chunk back to back
  task automatic lineRead(input logic [2:0] slot, input logic qual, input int pre);
    @(posedge clk);
    while (busNotReadyOut !== 1'b0) @(posedge clk);
    {rdIssue, rdIssueSlot, rdIssueQualified} <= {1'b1, slot, qual};
    @(posedge clk);
    {rdIssue, rdIssueSlot, rdIssueQualified} <= {1'b0, ~slot, ~qual};
    repeat (pre) @(posedge clk);
    for (int i = 0; i < cbeq_pkg::LINE_CHUNKS; i++) begin
      @(posedge clk);
      {rdChunk, rdChunkSlot} <= {1'b1, slot};
    end
    @(posedge clk);
    {rdChunk, rdChunkSlot} <= {1'b0, ~slot};
  endtask : lineRead

  // Data-valid burst of n bus cycles
  task automatic burst(input int n);
    @(posedge clk);
    dataValidPin <= 1'b1;
    repeat (n) @(posedge clk);
    dataValidPin <= 1'b0;
  endtask : burst

  // Transaction load held for n cycles, then idle
  task automatic load(input logic [3:0] lvl, input int n);
    @(posedge clk);
    txnCount <= lvl;
    repeat (n) @(posedge clk);
    txnCount <= 4'h0;
  endtask : load
endmodule : cbeq_bus_agent

// ===== test/test_cache_bus_event_qualifier.sv
// Purpose: Self-checking bench for the cache and bus event qualifier
// Assumes: Counts are read back through the accumulator register
// Notes: Read latency is checked against pre + 6, then relatively for a longer gap
`timescale 1ns/100ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin badCount++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module test_cache_bus_event_qualifier;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, rdIssue, rdIssueQualified, rdChunk, dataValidPin;
  logic ownDataDrive, busNotReadyOut, busNotReadyOe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv, a0, highCycles;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [2:0] rdIssueSlot, rdChunkSlot;
  logic [3:0] txnCount, incCount, coreEv;
  int badCount, cmpCount;
  localparam logic [7:0] TC [7] = '{cbeq_pkg::EV_PRE_MISS, cbeq_pkg::EV_PRE_MISS,
    cbeq_pkg::EV_LOAD_HIT_PRE, cbeq_pkg::EV_L1_PF_REQ, cbeq_pkg::EV_PRE_MISS,
    cbeq_pkg::EV_L1_PF_REQ, cbeq_pkg::EV_DATA_VALID};
  localparam logic [7:0] TM [7] = '{cbeq_pkg::UM_ALL_LEVEL, cbeq_pkg::UM_SECOND_LEVEL,
    8'h00, cbeq_pkg::UM_L1_PF_REQ, 8'h00, 8'h01, 8'h00};
  localparam logic [31:0] TE [7] = '{32'h1, 32'h2, 32'h3, 32'h5, 32'h0, 32'h0, 32'h0};

  cbeq_qualifier u_cbeq_qualifier (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .allLevelPfMiss(coreEv[0]), .secondLevelPfMiss(coreEv[1]),
    .loadHitPendingPf(coreEv[2]), .firstLevelPfReq(coreEv[3]), .rdIssueSlot, .rdIssue,
    .rdIssueQualified, .rdChunkSlot, .rdChunk, .txnCount, .dataValidPin, .ownDataDrive,
    .busNotReadyOut, .busNotReadyOe, .incCount);
  cbeq_bus_agent u_cbeq_bus_agent (.clk, .busNotReadyOut, .rdIssueSlot, .rdIssue,
    .rdIssueQualified, .rdChunkSlot, .rdChunk, .txnCount, .dataValidPin);

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Tally not-ready cycles; the enable must follow the driven level
  always @(posedge clk) begin
    if (sys_rst === 1'b0 && busNotReadyOut === 1'b1) highCycles <= highCycles + 1;
    if (sys_rst === 1'b0) `CHK(busNotReadyOe, busNotReadyOut)
  end

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : endSim

  // Write: address and data offered together, each dropped when taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rv, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axiRead

  task automatic setSel(input logic [7:0] c, input logic [7:0] m);
    axiWrite(cbeq_pkg::ADDR_SELECT, {16'h0, m, c});
    axiWrite(cbeq_pkg::ADDR_COUNT, 32'h0);
  endtask : setSel

  // Let the pipeline drain, then fetch the accumulator
  task automatic cnt();
    repeat (10) @(posedge clk);
    axiRead(cbeq_pkg::ADDR_COUNT);
  endtask : cnt

  // Back-to-back pulses, a different number on each core event
  task automatic fire();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      coreEv <= {i < 5, i < 3, i < 2, i < 1};
    end
    @(posedge clk);
    coreEv <= 4'h0;
  endtask : fire

  // Watchdog well beyond the few hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    endSim();
  end

  initial begin
    {badCount, cmpCount, highCycles, coreEv, ownDataDrive} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    axiRead(cbeq_pkg::ADDR_SELECT);
    `CHK(rv, cbeq_pkg::SELECT_RESET)
    axiRead(cbeq_pkg::ADDR_THRESH);
    `CHK(rv[3:0], cbeq_pkg::THRESH_RESET)
    axiRead(8'h10);
    `CHK({rr, rv}, {cbeq_pkg::AXI_SLVERR, 32'h0})
    axiWrite(8'h14, 32'h0);
    `CHK(rr, cbeq_pkg::AXI_SLVERR)
    // Every listed core pair, plus unlisted pairs that must stay silent
    for (int k = 0; k < 7; k++) begin
      setSel(TC[k], TM[k]);
      fire();
      cnt();
      `CHK(rv, TE[k])
    end
    // Outstanding reads: a later last chunk adds exactly the extra gap
    setSel(cbeq_pkg::EV_RD_OUTST, 8'h00);
    u_cbeq_bus_agent.lineRead(3'h0, 1'b1, 5);
    cnt();
    a0 = rv;
    // Issue cycle, pre plus one idle cycles, four chunk cycles: pre + 6
    `CHK(rv, 32'd11)
    axiWrite(cbeq_pkg::ADDR_COUNT, 32'h0);
    u_cbeq_bus_agent.lineRead(3'h1, 1'b1, 15);
    cnt();
    `CHK(rv, a0 + 32'd10)
    axiWrite(cbeq_pkg::ADDR_COUNT, 32'h0);
    u_cbeq_bus_agent.lineRead(3'h2, 1'b0, 5);
    cnt();
    `CHK(rv, 32'h0)
    // Hold-off: a single near-full cycle, then a long one, then a raised threshold
    setSel(cbeq_pkg::EV_HOLD_OFF, 8'h00);
    u_cbeq_bus_agent.load(4'hf, 1);
    cnt();
    `CHK(rv, 32'h1)
    `CHK(highCycles, 32'h2)
    u_cbeq_bus_agent.load(4'hf, 5);
    cnt();
    a0 = rv;
    // Five near-full cycles start two hold-offs, on top of the first one
    `CHK(a0, 32'h3)
    `CHK(highCycles, 2 * a0)
    axiRead(cbeq_pkg::ADDR_STATUS);
    `CHK(rv[31:16], a0[15:0])
    axiWrite(cbeq_pkg::ADDR_THRESH, 32'hf);
    u_cbeq_bus_agent.load(4'hc, 5);
    cnt();
    `CHK(rv, a0)
    // Data-valid cycles: an own burst and a foreign one, each agent mask
    for (int k = 0; k < 2; k++) begin
      setSel(cbeq_pkg::EV_DATA_VALID, k ? cbeq_pkg::UM_THIS_AGENT : cbeq_pkg::UM_ALL_AGENTS);
      ownDataDrive <= 1'b1;
      u_cbeq_bus_agent.burst(6);
      repeat (12) @(posedge clk);
      ownDataDrive <= 1'b0;
      u_cbeq_bus_agent.burst(4);
      cnt();
      `CHK(rv, k ? 32'd6 : 32'd10)
    end
    endSim();
  end
endmodule : test_cache_bus_event_qualifier
